// File: rtl/rco_cfg.svh
// Constants of the reference clock output block
`ifndef RCO_CFG_SVH
`define RCO_CFG_SVH

// Register indices; byte address is four times the index
`define RCO_CTRL_IDX    12'h895
`define RCO_SRC_IDX     12'h896
`define RCO_STAT_IDX    12'h897

// Reset values
`define RCO_CTRL_RST    8'h10
`define RCO_SRC_RST     4'h0

// Control field positions
`define RCO_EN_BIT      7
`define RCO_DC_HI       4
`define RCO_DC_LO       3
`define RCO_DIV_HI      2
`define RCO_DIV_LO      0
`define RCO_CTRL_WMASK  8'h9F

// Source field
`define RCO_SRC_HI      3
`define RCO_SRC_SYS     4'h0
`define RCO_SRC_LAST    4'hA
`define RCO_NUM_SRC     11

// Duty encodings
`define RCO_DC_0        2'h0
`define RCO_DC_25       2'h1
`define RCO_DC_50       2'h2
`define RCO_DC_75       2'h3

// Status bit positions
`define RCO_STAT_RUN    0
`define RCO_STAT_OUT    1
`define RCO_STAT_SLEEP  2

`endif

// File: rtl/rco_pkg.sv
// Types of the reference clock output block
package rco_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } rco_state_t;

  typedef logic [3:0] rco_src_t;
  typedef logic [1:0] rco_duty_t;
  typedef logic [2:0] rco_div_t;

endpackage

// File: rtl/rco_sync.sv
// Two-stage synchroniser for the source clock levels
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_sync
  import rco_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire logic [`RCO_NUM_SRC-1:0] i_d,
  output logic      [`RCO_NUM_SRC-1:0] o_q
);

  logic [`RCO_NUM_SRC-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule // rco_sync

// File: rtl/rco_top.sv
// Reference clock output: source pick, divider, duty shaping, APB registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_top
  import rco_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_sleep,
  input  wire logic        i_src_sys_clk,
  input  wire logic        i_src_fast_internal_osc,
  input  wire logic        i_src_slow_internal_osc,
  input  wire logic        i_src_medium_osc_500k,
  input  wire logic        i_src_medium_osc_32k,
  input  wire logic        i_src_secondary_osc,
  input  wire logic        i_src_numeric_osc_gen,
  input  wire logic [3:0]  i_src_logic_cell,
  output logic             o_ref_out_pin,
  output logic             o_ref_clk_int
);

  // Register state
  logic [7:0]  ctrl_q;
  rco_src_t    src_q;
  logic [31:0] prdata_q;

  // Divider state
  rco_state_t  state_q;
  rco_state_t  state_d;
  logic [7:0]  hp_q;
  logic [7:0]  hp_d;
  logic        out_q;
  logic        out_d;
  logic        lvl_q;
  logic        lvl_prev_q;

  logic [`RCO_NUM_SRC-1:0] src_raw;
  logic [`RCO_NUM_SRC-1:0] src_sync;

  logic        en;
  rco_duty_t   dc;
  rco_div_t    div;
  logic        src_ok;
  logic        sleep_stop;
  logic        allowed;
  logic        rise;
  logic        toggle;

  logic        apb_setup;
  logic        apb_access;
  logic        hit_ctrl;
  logic        hit_src;
  logic        hit_stat;
  logic        hit_any;

  // Byte address of a register index; upper and lane bits must be zero
  function automatic logic f_hit(input logic [15:0] addr, input logic [11:0] idx);
    f_hit = (addr[15:14] == 2'h0) && (addr[13:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Divisor from the divide code
  function automatic logic [7:0] f_divisor(input rco_div_t code);
    f_divisor = 8'h01 << code;
  endfunction

  // Last half-period index of one output period
  function automatic logic [7:0] f_last(input rco_div_t code);
    logic [8:0] twice;
    twice  = {f_divisor(code), 1'b0};
    f_last = 8'(twice - 9'h001);
  endfunction

  // Half-periods of high time per output period
  function automatic logic [7:0] f_thr(input rco_duty_t duty, input rco_div_t code);
    logic [7:0] d;
    d = f_divisor(code);
    if (duty == `RCO_DC_25) begin
      f_thr = d >> 1;
    end else if (duty == `RCO_DC_50) begin
      f_thr = d;
    end else if (duty == `RCO_DC_75) begin
      f_thr = 8'(d + (d >> 1));
    end else begin
      f_thr = 8'h00;
    end
  endfunction

  // Level of the chosen source; reserved codes give low
  function automatic logic f_pick(input logic [`RCO_NUM_SRC-1:0] v, input rco_src_t code);
    if (code <= `RCO_SRC_LAST) begin
      f_pick = v[code];
    end else begin
      f_pick = 1'b0;
    end
  endfunction

  // Sources arrive in their own clock domains
  assign src_raw = {i_src_logic_cell,
                    i_src_numeric_osc_gen,
                    i_src_secondary_osc,
                    i_src_medium_osc_32k,
                    i_src_medium_osc_500k,
                    i_src_slow_internal_osc,
                    i_src_fast_internal_osc,
                    i_src_sys_clk};

  rco_sync u_rco_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (src_raw),
    .o_q    (src_sync)
  );

  assign en         = ctrl_q[`RCO_EN_BIT];
  assign dc         = ctrl_q[`RCO_DC_HI:`RCO_DC_LO];
  assign div        = ctrl_q[`RCO_DIV_HI:`RCO_DIV_LO];
  assign src_ok     = (src_q <= `RCO_SRC_LAST);
  assign sleep_stop = i_sleep && (src_q == `RCO_SRC_SYS);
  assign allowed    = en && src_ok && !sleep_stop;
  assign rise       = lvl_q && !lvl_prev_q;
  assign toggle     = lvl_q ^ lvl_prev_q;

  // APB decode
  assign apb_setup  = i_psel && !i_penable;
  assign apb_access = i_psel && i_penable;
  assign hit_ctrl   = f_hit(i_paddr, `RCO_CTRL_IDX);
  assign hit_src    = f_hit(i_paddr, `RCO_SRC_IDX);
  assign hit_stat   = f_hit(i_paddr, `RCO_STAT_IDX);
  assign hit_any    = hit_ctrl || hit_src || hit_stat;

  // Zero wait states; error only on unmapped addresses
  assign o_pready   = 1'b1;
  assign o_pslverr  = apb_access && !hit_any;
  assign o_prdata   = prdata_q;

  // Control register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= `RCO_CTRL_RST;
    end else if (apb_access && i_pwrite && i_pstrb[0] && hit_ctrl) begin
      // Live changes of divide or duty are taken as written, glitches allowed
      ctrl_q <= i_pwdata[7:0] & `RCO_CTRL_WMASK;
    end
  end

  // Source select register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      src_q <= `RCO_SRC_RST;
    end else if (apb_access && i_pwrite && i_pstrb[0] && hit_src) begin
      src_q <= i_pwdata[`RCO_SRC_HI:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup && !i_pwrite) begin
      if (hit_ctrl) begin
        prdata_q <= {24'h000000, ctrl_q};
      end else if (hit_src) begin
        prdata_q <= {28'h0000000, src_q};
      end else if (hit_stat) begin
        prdata_q <= {29'h0000000, sleep_stop, out_q, state_q == ST_RUN};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Selected level and its previous value for edge finding
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lvl_q      <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else begin
      lvl_q      <= f_pick(src_sync, src_q);
      lvl_prev_q <= lvl_q;
    end
  end

  // Start waits for a source rising edge so the first pulse is whole
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (allowed) begin
          state_d = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!allowed) begin
          state_d = ST_OFF;
        end else if (rise) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!allowed) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Half-period counter over both source edges
  always_comb begin
    hp_d = hp_q;
    if (state_d != ST_RUN) begin
      hp_d = 8'h00;
    end else if (state_q != ST_RUN) begin
      hp_d = 8'h00;
    end else if (toggle) begin
      if (hp_q >= f_last(div)) begin
        hp_d = 8'h00;
      end else begin
        hp_d = 8'(hp_q + 8'h01);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hp_q <= 8'h00;
    end else begin
      hp_q <= hp_d;
    end
  end

  // Output shaping; leaving run forces low on the same edge
  always_comb begin
    if (state_d != ST_RUN) begin
      out_d = 1'b0;
    end else if (dc == `RCO_DC_0) begin
      out_d = 1'b0;
    end else if (div == 3'h0) begin
      out_d = lvl_q;
    end else begin
      out_d = (hp_d < f_thr(dc, div));
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // Pin and internal consumers share one flop
  assign o_ref_out_pin = out_q;
  assign o_ref_clk_int = out_q;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_src_follow: assert property (
    $stable(src_q) && src_ok |=> lvl_q == $past(src_sync[src_q])
  ) else $error("selected level does not follow chosen source");

  a_arm_quiet: assert property (
    state_q == ST_ARM |-> !out_q
  ) else $error("output active before first source edge");

  a_start_high: assert property (
    state_q == ST_ARM && allowed && rise && dc != `RCO_DC_0 ##1 $stable(ctrl_q) |-> out_q
  ) else $error("first output pulse missing after start");

  a_stop_now: assert property (
    !en |=> !out_q && state_q == ST_OFF
  ) else $error("output not stopped after disable");

  a_div_range: assert property (
    state_q == ST_RUN && $stable(ctrl_q) |-> hp_q <= f_last(div)
  ) else $error("half-period count beyond divisor");

  a_duty_level: assert property (
    state_q == ST_RUN && div != 3'h0 && dc != `RCO_DC_0 && $stable(ctrl_q)
      |-> out_q == (hp_q < f_thr(dc, div))
  ) else $error("output level wrong for duty setting");

  a_duty_zero: assert property (
    dc == `RCO_DC_0 ##1 dc == `RCO_DC_0 |-> !out_q
  ) else $error("output high with zero duty");

  a_sleep_sys: assert property (
    i_sleep && src_q == `RCO_SRC_SYS |=> !out_q
  ) else $error("output running in sleep on system clock");

  a_sleep_runs: assert property (
    state_q == ST_RUN && en && src_ok && src_q != `RCO_SRC_SYS |=> state_q == ST_RUN
  ) else $error("divider stopped without cause");

  a_reserved_low: assert property (
    !src_ok |=> !out_q
  ) else $error("output active with reserved source");

  a_pass_level: assert property (
    state_q == ST_RUN && div == 3'h0 && dc != `RCO_DC_0 && $stable(ctrl_q) |-> out_q == $past(lvl_q)
  ) else $error("undivided output does not follow source");

  a_out_allowed: assert property (
    out_q |-> $past(en) && $past(src_ok) && !$past(sleep_stop)
  ) else $error("output high while disabled or stopped");

  c_run_div: cover property (
    state_q == ST_RUN && div == 3'h3 && dc == `RCO_DC_75 && $rose(out_q)
  );
  c_run_pass: cover property (
    state_q == ST_RUN && div == 3'h0 && $fell(out_q)
  );
  c_sleep_run: cover property (
    i_sleep && state_q == ST_RUN && src_q == 4'h5
  );
  c_bad_addr: cover property (
    o_pslverr
  );

endmodule // rco_top

// File: tb/rco_src_model.sv
// Stand-in for the device clock sources feeding the reference output
`timescale 1ns/1ps
module rco_src_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  output logic      [10:0] o_src
);
  // Source k toggles every 3+k cycles; 3 is the shortest that gets counted
  int cnt_q [11];
  always_ff @(posedge i_clk or negedge i_nrst) begin
    for (int k = 0; k < 11; k++) begin
      if (!i_nrst) begin
        cnt_q[k] <= 0;
        o_src[k] <= 1'b0;
      end else if (cnt_q[k] == 2 + k) begin
        cnt_q[k] <= 0;
        o_src[k] <= ~o_src[k];
      end else begin
        cnt_q[k] <= cnt_q[k] + 1;
      end
    end
  end
endmodule // rco_src_model

// File: tb/tb_rco_top.sv
// Register-level testbench of the reference clock output
`timescale 1ns/1ps
`include "rco_cfg.svh"
module tb_rco_top;
  import rco_pkg::*;
  localparam logic [15:0] CTRL = {2'b00, `RCO_CTRL_IDX, 2'b00};
  localparam logic [15:0] SRC  = {2'b00, `RCO_SRC_IDX, 2'b00};
  localparam logic [15:0] STAT = {2'b00, `RCO_STAT_IDX, 2'b00};
  logic        i_clk, i_nrst, psel, pen, pwr, slp;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pin, pint;
  logic [10:0] src;
  int          fails, comparisons;
  logic [31:0] r;
  logic        e;

  rco_src_model u_rco_src_model (.i_clk(i_clk), .i_nrst(i_nrst), .o_src(src));
  rco_top u_rco_top (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sleep(slp), .i_src_sys_clk(src[0]), .i_src_fast_internal_osc(src[1]),
    .i_src_slow_internal_osc(src[2]), .i_src_medium_osc_500k(src[3]),
    .i_src_medium_osc_32k(src[4]), .i_src_secondary_osc(src[5]), .i_src_numeric_osc_gen(src[6]),
    .i_src_logic_cell(src[10:7]), .o_ref_out_pin(pin), .o_ref_clk_int(pint)
  );

  always #2.5 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    // The wait for the answer ends when pready is high, or on the watchdog
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Expected high and low times in clock cycles from source, divide and duty
  task automatic run(input int s, input int dv, input int dc);
    int hi, lo, mm, hp, d;
    d = 1 << dv;
    hp = 3 + s;
    apb(1'b1, CTRL, 32'(dc * 8 + dv));
    apb(1'b1, SRC, 32'(s));
    apb(1'b1, CTRL, 32'(128 + dc * 8 + dv));
    hi = 0;
    lo = 0;
    mm = 0;
    if (dc == 0 || s > 10 || (slp && s == 0)) begin
      repeat (300) begin
        @(posedge i_clk) #1;
        if (pin !== 1'b0) hi++;
      end
      chk("held low", 0, hi);
      return;
    end
    while (pin !== 1'b1 && lo < 3000) begin
      @(posedge i_clk) #1;
      lo++;
    end
    lo = 0;
    while (pin === 1'b1 && hi < 3000) begin
      @(posedge i_clk) #1;
      hi++;
      if (pint !== pin) mm++;
    end
    while (pin !== 1'b1 && lo < 3000) begin
      @(posedge i_clk) #1;
      lo++;
    end
    chk("high time", dv == 0 ? hp : hp * d * dc / 2, hi);
    chk("low time", dv == 0 ? hp : hp * d * (4 - dc) / 2, lo);
    chk("internal copy", 0, mm);
  endtask

  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    end_sim();
  end

  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    {psel, pen, pwr, slp} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    chk("ctrl reset", 32'h10, r);
    chk("mapped err", 0, e);
    apb(1'b0, SRC, 32'h0);
    chk("src reset", 32'h0, r);
    chk("pin reset", 0, pin);
    apb(1'b0, 16'h2260, 32'h0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    apb(1'b1, CTRL, 32'h7F);
    apb(1'b0, CTRL, 32'h0);
    chk("ctrl mask", 32'h1F, r);
    $display("test registers done");
    for (int s = 0; s < 11; s++) run(s, 0, 2);
    for (int dv = 1; dv < 8; dv++) run(1, dv, 2);
    for (int dc = 0; dc < 4; dc++) run(2, 2, dc);
    for (int dc = 0; dc < 4; dc++) run(2, 0, dc);
    $display("test divide and duty done");
    run(1, 3, 3);
    apb(1'b1, CTRL, 32'h1B);
    repeat (1) @(posedge i_clk);
    #1;
    chk("stop at once", 0, pin);
    run(11, 1, 2);
    @(posedge i_clk);
    slp <= 1'b1;
    run(1, 1, 2);
    run(0, 1, 2);
    apb(1'b0, STAT, 32'h0);
    chk("sleep status", 32'h4, r);
    @(posedge i_clk);
    slp <= 1'b0;
    run(0, 1, 2);
    $display("test stop and sleep done");
    end_sim();
  end
endmodule // tb_rco_top
